// ==== hw/cmsr_core_regs.v ====
// Core mode, privilege and stack register file
// Overview of operation
// - Core starts in thread mode when reset is released.
// - Exceptions run in handler mode; return brings thread mode back.
// - Handler mode always runs privileged.
// - In thread mode, control bit 0 picks privileged or unprivileged.
// - Unprivileged code gets limited special moves and no priority-state change.
// - Unprivileged code cannot reach timer, interrupt controller or control block.
// - Unprivileged code enters privileged software only through supervisor call.
// - Privileged code reaches everything, including writing the control register.
// - Push decrements the stack pointer first, then writes at new address.
// - Thread mode control bit 1 picks process stack; zero, the reset value, main.
// - Handler mode always uses the main stack pointer.
// - At reset main stack pointer loads from word at address zero.
// - At reset the link register loads 32'h0fff_ffff, top four bits clear.
// - At reset instruction pointer loads reset vector; bit 0 sets state bit.
// - General registers 0..12 are 32 bits, usable at any privilege.
// - Status word holds flags, number and exec views as disjoint fields.
// - Any view or combination is accessible; number-exec pair is read-only.
// - Number bits ignore writes; exec bits read zero and ignore writes.
// - Flag-target write with flags-only set updates only the N, Z, C, V, Q bits; the code applies flags-only to the flags view alone.
// - General, process SP, link, pointer and flags unprivileged; rest privileged.
`timescale 1ns/10ps
`include "cmsr_defs.vh"

module cmsr_core_regs
#(
   parameter NUM_W = 9
)
(
   // Clock and reset
   input wire clock,
   input wire reset,
   // Reset vector fetch
   output reg vec_req,
   output reg [31:0] vec_addr,
   input wire vec_ack,
   input wire [31:0] vec_data,
   // Exception entry and return
   input wire exc_enter,
   input wire [NUM_W-1:0] exc_number,
   input wire exc_return,
   // Core register port
   input wire gpr_we,
   input wire [3:0] gpr_waddr,
   input wire [31:0] gpr_wdata,
   input wire [3:0] gpr_raddr,
   output reg [31:0] gpr_rdata,
   // Stack push and pop
   input wire push,
   input wire pop,
   // Arithmetic flag update from the datapath
   input wire flags_we,
   input wire [31:0] flags_wdata,
   // Special register moves
   input wire sr_write,
   input wire sr_read,
   input wire sr_flags_only,
   input wire [4:0] sr_sel,
   input wire [31:0] sr_wdata,
   output reg [31:0] sr_rdata,
   output reg sr_denied,
   // Privilege checks for other operations
   input wire cps_req,
   input wire sys_access,
   input wire svc_req,
   output reg op_denied,
   output reg svc_taken,
   // Mode and state
   output reg running,
   output reg handler_mode,
   output reg privileged,
   output reg use_psp,
   output reg [31:0] sp_value,
   output reg [31:0] push_addr,
   output reg [31:0] status_word,
   output reg irq_masked,
   output reg all_masked,
   output reg [7:0] prio_level
);

   reg [31:0] gpr_reg [0:12];
   reg [31:0] msp_reg;
   reg [31:0] psp_reg;
   reg [31:0] link_reg;
   reg [31:0] ip_reg;
   reg [31:0] flags_reg;
   reg [NUM_W-1:0] number_reg;
   reg [31:0] exec_reg;
   reg irq_mask_reg;
   reg all_mask_reg;
   reg [7:0] prio_reg;
   reg [1:0] control_reg;
   reg handler_reg;
   reg [1:0] rs_reg;
   reg vec_ack_s1_reg;
   reg vec_ack_s2_reg;
   reg [31:0] vec_data_s1_reg;
   reg [31:0] vec_data_s2_reg;
   reg ack_clear_reg;

   // Handler mode forces privilege and the main stack
   wire priv_now = handler_reg | ~control_reg[`CMSR_CTRL_UNPRIV];
   wire psp_now = ~handler_reg & control_reg[`CMSR_CTRL_SPSEL];
   wire [31:0] sp_now = psp_now ? psp_reg : msp_reg;
   // Full descending: a push lands one word below the current pointer
   wire [31:0] sp_dec = sp_now - 32'h0000_0004;
   wire [31:0] sp_inc = sp_now + 32'h0000_0004;
   wire [31:0] number_word = {{(32-NUM_W){1'b0}}, number_reg};
   wire is_run = (rs_reg == `CMSR_RS_RUN);

   // Selector privilege: unprivileged may reach only the flags view and process stack
   reg sel_ok;
   reg sel_priv;
   reg sel_ro;
   reg [31:0] sel_read;
   reg [31:0] sel_wmask;
   always @*
   begin
      sel_ok = 1'b1;
      sel_priv = 1'b1;
      sel_ro = 1'b0;
      sel_read = `CMSR_ZERO;
      sel_wmask = `CMSR_ZERO;
      case (sr_sel)
         `CMSR_SEL_FLAGS:
         begin
            sel_priv = 1'b0;
            sel_read = flags_reg;
            sel_wmask = sr_flags_only ? `CMSR_NZCVQ_MASK : `CMSR_FLAGS_MASK;
         end
         `CMSR_SEL_NUM_FLAGS:
         begin
            sel_read = flags_reg | number_word;
            sel_wmask = `CMSR_FLAGS_MASK;
         end
         `CMSR_SEL_FLAGS_EXEC:
         begin
            sel_read = flags_reg;
            sel_wmask = `CMSR_FLAGS_MASK;
         end
         `CMSR_SEL_STATUS:
         begin
            sel_read = flags_reg | number_word;
            sel_wmask = `CMSR_FLAGS_MASK;
         end
         `CMSR_SEL_NUMBER:
         begin
            sel_read = number_word;
            sel_ro = 1'b1;
         end
         `CMSR_SEL_EXEC:
         begin
            sel_ro = 1'b1;
         end
         `CMSR_SEL_NUM_EXEC:
         begin
            sel_read = number_word;
            sel_ro = 1'b1;
         end
         `CMSR_SEL_MSP: sel_read = msp_reg;
         `CMSR_SEL_PSP:
         begin
            sel_priv = 1'b0;
            sel_read = psp_reg;
         end
         `CMSR_SEL_IRQ_MASK: sel_read = {31'h0000_0000, irq_mask_reg};
         `CMSR_SEL_PRIO, `CMSR_SEL_PRIO_MAX: sel_read = {24'h00_0000, prio_reg};
         `CMSR_SEL_ALL_MASK: sel_read = {31'h0000_0000, all_mask_reg};
         `CMSR_SEL_CONTROL: sel_read = {30'h0000_0000, control_reg};
         default: sel_ok = 1'b0;
      endcase
   end

   wire sel_allowed = sel_ok & (priv_now | ~sel_priv);
   // Read-only views drop writes silently, without a denial
   wire do_write = is_run & sr_write & sel_allowed & ~sel_ro;
   wire [31:0] wr_val = sr_wdata;

   // Synchronise the vector fetch answer
   // Data is only used while the acknowledge stands, so it has settled by then
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         vec_ack_s1_reg <= 1'b0;
         vec_ack_s2_reg <= 1'b0;
         vec_data_s1_reg <= `CMSR_ZERO;
         vec_data_s2_reg <= `CMSR_ZERO;
      end
      else
      begin
         vec_ack_s1_reg <= vec_ack;
         vec_ack_s2_reg <= vec_ack_s1_reg;
         vec_data_s1_reg <= vec_data;
         vec_data_s2_reg <= vec_data_s1_reg;
      end
   end

   // Reset sequence, modes and special registers
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rs_reg <= `CMSR_RS_FETCH_SP;
         msp_reg <= `CMSR_ZERO;
         psp_reg <= `CMSR_ZERO;
         link_reg <= `CMSR_LINK_RESET;
         ip_reg <= `CMSR_ZERO;
         flags_reg <= `CMSR_ZERO;
         number_reg <= {NUM_W{1'b0}};
         exec_reg <= `CMSR_EXEC_RESET;
         irq_mask_reg <= 1'b0;
         all_mask_reg <= 1'b0;
         prio_reg <= 8'h00;
         control_reg <= 2'b00;
         ack_clear_reg <= 1'b0;
         handler_reg <= 1'b0;
      end
      else
      begin
         case (rs_reg)
            `CMSR_RS_FETCH_SP:
            begin
               if (vec_ack_s2_reg)
               begin
                  msp_reg <= vec_data_s2_reg;
                  ack_clear_reg <= 1'b0;
                  rs_reg <= `CMSR_RS_FETCH_IP;
               end
            end
            `CMSR_RS_FETCH_IP:
            begin
               // Wait for the previous acknowledge to drop before taking the next word
               if (!vec_ack_s2_reg)
                  ack_clear_reg <= 1'b1;
               if (vec_ack_s2_reg && ack_clear_reg)
               begin
                  ip_reg <= {vec_data_s2_reg[31:1], 1'b0};
                  exec_reg[`CMSR_TBIT] <= vec_data_s2_reg[0];
                  rs_reg <= `CMSR_RS_RUN;
               end
            end
            `CMSR_RS_RUN:
            begin
               if (exc_enter)
               begin
                  handler_reg <= 1'b1;
                  number_reg <= exc_number;
               end
               else if (exc_return)
               begin
                  handler_reg <= 1'b0;
                  number_reg <= {NUM_W{1'b0}};
               end
               if (gpr_we)
               begin
                  // The stack index lands in whichever copy is active
                  if (gpr_waddr == `CMSR_IDX_SP)
                  begin
                     if (psp_now)
                        psp_reg <= gpr_wdata;
                     else
                        msp_reg <= gpr_wdata;
                  end
                  if (gpr_waddr == `CMSR_IDX_LINK)
                     link_reg <= gpr_wdata;
                  if (gpr_waddr == `CMSR_IDX_IP)
                     ip_reg <= {gpr_wdata[31:1], 1'b0};
               end
               else if (push || pop)
               begin
                  if (psp_now)
                     psp_reg <= push ? sp_dec : sp_inc;
                  else
                     msp_reg <= push ? sp_dec : sp_inc;
               end
               // A special-register write in the same cycle overrides the datapath
               if (flags_we)
                  flags_reg <= flags_wdata & `CMSR_FLAGS_MASK;
               if (do_write)
               begin
                  case (sr_sel)
                     `CMSR_SEL_FLAGS, `CMSR_SEL_NUM_FLAGS, `CMSR_SEL_FLAGS_EXEC, `CMSR_SEL_STATUS:
                        flags_reg <= (flags_reg & ~sel_wmask) | (wr_val & sel_wmask);
                     `CMSR_SEL_MSP: msp_reg <= wr_val;
                     `CMSR_SEL_PSP: psp_reg <= wr_val;
                     `CMSR_SEL_IRQ_MASK: irq_mask_reg <= wr_val[0];
                     `CMSR_SEL_PRIO: prio_reg <= wr_val[7:0];
                     `CMSR_SEL_PRIO_MAX:
                     begin
                        // Only raises priority, never lowers it
                        if (wr_val[7:0] != 8'h00 && (prio_reg == 8'h00 || wr_val[7:0] < prio_reg))
                           prio_reg <= wr_val[7:0];
                     end
                     `CMSR_SEL_ALL_MASK: all_mask_reg <= wr_val[0];
                     `CMSR_SEL_CONTROL: control_reg <= wr_val[1:0];
                     default: control_reg <= control_reg;
                  endcase
               end
            end
            // Unused code restarts the vector fetch
            default: rs_reg <= `CMSR_RS_FETCH_SP;
         endcase
      end
   end

   // General-purpose bank, no reset value
   // Indices 13 to 15 are handled in the main process
   always @(posedge clock)
   begin
      if (is_run && gpr_we && gpr_waddr < `CMSR_IDX_SP)
         gpr_reg[gpr_waddr] <= gpr_wdata;
   end

   // Registered outputs
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         vec_req <= 1'b0;
         vec_addr <= `CMSR_SP_VECTOR;
         gpr_rdata <= `CMSR_ZERO;
         sr_rdata <= `CMSR_ZERO;
         sr_denied <= 1'b0;
         op_denied <= 1'b0;
         svc_taken <= 1'b0;
         running <= 1'b0;
         handler_mode <= 1'b0;
         privileged <= 1'b1;
         use_psp <= 1'b0;
         sp_value <= `CMSR_ZERO;
         push_addr <= `CMSR_ZERO;
         status_word <= `CMSR_ZERO;
         irq_masked <= 1'b0;
         all_masked <= 1'b0;
         prio_level <= 8'h00;
      end
      else
      begin
         // Request held until acknowledge seen, dropped once per word
         vec_req <= (rs_reg != `CMSR_RS_RUN) && !vec_ack_s2_reg;
         vec_addr <= (rs_reg == `CMSR_RS_FETCH_SP) ? `CMSR_SP_VECTOR : `CMSR_IP_VECTOR;
         case (gpr_raddr)
            `CMSR_IDX_SP: gpr_rdata <= sp_now;
            `CMSR_IDX_LINK: gpr_rdata <= link_reg;
            `CMSR_IDX_IP: gpr_rdata <= ip_reg;
            default: gpr_rdata <= gpr_reg[gpr_raddr];
         endcase
         sr_rdata <= (sr_read && sel_allowed) ? sel_read : `CMSR_ZERO;
         // Denials are registered, one cycle after the request and for as long as it is held
         sr_denied <= is_run & (sr_read | sr_write) & ~sel_allowed;
         op_denied <= is_run & (cps_req | sys_access) & ~priv_now;
         svc_taken <= is_run & svc_req;
         running <= is_run;
         handler_mode <= handler_reg;
         privileged <= priv_now;
         use_psp <= psp_now;
         sp_value <= sp_now;
         push_addr <= sp_dec;
         // Exec bits show here, yet read zero through the moves
         status_word <= flags_reg | number_word | exec_reg;
         irq_masked <= irq_mask_reg;
         all_masked <= all_mask_reg;
         prio_level <= prio_reg;
      end
   end

endmodule

// ==== hw/cmsr_defs.vh ====
// Constants for the core mode and stack register file
`ifndef CMSR_DEFS_VH
`define CMSR_DEFS_VH
// Special register selectors on the access port
`define CMSR_SEL_FLAGS 5'h00
`define CMSR_SEL_NUM_FLAGS 5'h01
`define CMSR_SEL_FLAGS_EXEC 5'h02
`define CMSR_SEL_STATUS 5'h03
`define CMSR_SEL_NUMBER 5'h05
`define CMSR_SEL_EXEC 5'h06
`define CMSR_SEL_NUM_EXEC 5'h07
`define CMSR_SEL_MSP 5'h08
`define CMSR_SEL_PSP 5'h09
`define CMSR_SEL_IRQ_MASK 5'h10
`define CMSR_SEL_PRIO 5'h11
`define CMSR_SEL_PRIO_MAX 5'h12
`define CMSR_SEL_ALL_MASK 5'h13
`define CMSR_SEL_CONTROL 5'h14
// Core register indices
`define CMSR_IDX_SP 4'hd
`define CMSR_IDX_LINK 4'he
`define CMSR_IDX_IP 4'hf
// Status word field layout
`define CMSR_FLAGS_MASK 32'hf80f_0000
`define CMSR_NZCVQ_MASK 32'hf800_0000
`define CMSR_EXEC_MASK 32'h0700_fc00
`define CMSR_NUMBER_MASK 32'h0000_01ff
`define CMSR_TBIT 24
// Control bits
`define CMSR_CTRL_UNPRIV 0
`define CMSR_CTRL_SPSEL 1
// Reset values and vector addresses
`define CMSR_LINK_RESET 32'h0fff_ffff
`define CMSR_EXEC_RESET 32'h0100_0000
`define CMSR_SP_VECTOR 32'h0000_0000
`define CMSR_IP_VECTOR 32'h0000_0004
`define CMSR_ZERO 32'h0000_0000
// Reset sequence states
`define CMSR_RS_FETCH_SP 2'h0
`define CMSR_RS_FETCH_IP 2'h1
`define CMSR_RS_RUN 2'h2
`endif

// ==== verification/cmsr_core_regs_monitor.sv ====
// Concurrent property checker for the core mode and stack register file
`timescale 1ns/10ps
`include "cmsr_defs.vh"

module cmsr_core_regs_monitor (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Requests
   input wire exc_enter,
   input wire exc_return,
   input wire sr_read,
   input wire [4:0] sr_sel,
   input wire cps_req,
   input wire svc_req,
   // Answers and state
   input wire [31:0] sr_rdata,
   input wire sr_denied,
   input wire op_denied,
   input wire svc_taken,
   input wire running,
   input wire handler_mode,
   input wire privileged,
   input wire use_psp,
   input wire [31:0] sp_value,
   input wire [31:0] push_addr,
   input wire [31:0] status_word
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   AST_START_THREAD: assert property (!running |-> !handler_mode)
      else $error("handler mode before start");
   AST_ENTER: assert property (running && exc_enter |-> ##[1:2] handler_mode)
      else $error("no handler mode on entry");
   AST_RETURN: assert property (running && exc_return && !exc_enter |-> ##[1:2] !handler_mode)
      else $error("no thread mode on return");
   AST_HANDLER_PRIV: assert property (handler_mode |-> privileged)
      else $error("handler mode unprivileged");
   AST_HANDLER_MAIN: assert property (handler_mode |-> !use_psp)
      else $error("handler mode on process stack");
   AST_PUSH_ADDR: assert property (running |-> push_addr == sp_value - 32'h0000_0004)
      else $error("push address not one word below");
   AST_TBIT: assert property (running |-> status_word[`CMSR_TBIT])
      else $error("state bit clear");
   AST_PRIV_ONLY: assert property (running && sr_read && sr_sel == `CMSR_SEL_CONTROL
      |=> sr_denied == !privileged && (privileged || sr_rdata == `CMSR_ZERO)) else $error("control read not refused");
   AST_EXEC_ZERO: assert property (running && sr_read && sr_sel == `CMSR_SEL_EXEC |=> sr_rdata == `CMSR_ZERO)
      else $error("exec view read not zero");
   AST_CPS: assert property (running && cps_req |=> op_denied == !privileged)
      else $error("priority change refusal wrong");
   AST_SVC: assert property (running && svc_req |=> svc_taken)
      else $error("supervisor call not taken");
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the core mode and stack register file
`timescale 1ns/10ps
`include "cmsr_defs.vh"

module tb;
   localparam P_ENTER = 7'h01;
   localparam P_RETURN = 7'h02;
   localparam P_PUSH = 7'h04;
   localparam P_POP = 7'h08;
   localparam P_CPS = 7'h10;
   localparam P_SVC = 7'h20;
   localparam P_SYS = 7'h40;
   reg clock = 1'b0;
   reg reset = 1'b1;
   reg vec_ack = 1'b0;
   reg [31:0] vec_data = 32'h0000_0000;
   reg [8:0] exc_number = 9'h000;
   reg gpr_we = 1'b0;
   reg [3:0] gpr_waddr = 4'h0;
   reg [31:0] gpr_wdata = 32'h0000_0000;
   reg [3:0] gpr_raddr = 4'h0;
   reg flags_we = 1'b0;
   reg [31:0] flags_wdata = 32'h0000_0000;
   reg sr_write = 1'b0;
   reg sr_read = 1'b0;
   reg sr_flags_only = 1'b0;
   reg [4:0] sr_sel = 5'h00;
   reg [31:0] sr_wdata = 32'h0000_0000;
   reg [6:0] pl = 7'h00;
   wire exc_enter, exc_return, push, pop, cps_req, svc_req, sys_access;
   wire vec_req, sr_denied, op_denied, svc_taken, running, handler_mode, privileged, use_psp, irq_masked, all_masked;
   wire [31:0] vec_addr, gpr_rdata, sr_rdata, sp_value, push_addr, status_word;
   wire [7:0] prio_level;
   integer num_errors = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer n;
   reg [31:0] rd;
   reg den;

   assign {sys_access, svc_req, cps_req, pop, push, exc_return, exc_enter} = pl;

   cmsr_core_regs DUT (
      .clock(clock), .reset(reset),
      .vec_req(vec_req), .vec_addr(vec_addr), .vec_ack(vec_ack), .vec_data(vec_data),
      .exc_enter(exc_enter), .exc_number(exc_number), .exc_return(exc_return),
      .gpr_we(gpr_we), .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata), .gpr_raddr(gpr_raddr), .gpr_rdata(gpr_rdata),
      .push(push), .pop(pop), .flags_we(flags_we), .flags_wdata(flags_wdata),
      .sr_write(sr_write), .sr_read(sr_read), .sr_flags_only(sr_flags_only), .sr_sel(sr_sel),
      .sr_wdata(sr_wdata), .sr_rdata(sr_rdata), .sr_denied(sr_denied),
      .cps_req(cps_req), .sys_access(sys_access), .svc_req(svc_req), .op_denied(op_denied), .svc_taken(svc_taken),
      .running(running), .handler_mode(handler_mode), .privileged(privileged), .use_psp(use_psp),
      .sp_value(sp_value), .push_addr(push_addr), .status_word(status_word),
      .irq_masked(irq_masked), .all_masked(all_masked), .prio_level(prio_level)
   );

   always #10 clock = ~clock;

   // Hang guard, generous against a run of some 110 cycles
   always @(posedge clock)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         num_errors = num_errors + 1;
         report_and_stop;
      end
   end

   task report_and_stop;
      begin
         $display("num_errors %0d comparisons %0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   task check32(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task check1(input got, input exp);
      begin
         check32({31'h0000_0000, got}, {31'h0000_0000, exp});
      end
   endtask

   task idle;
      begin
         repeat (2) @(negedge clock);
      end
   endtask

   // Full handshake; the word is held until the request falls
   task vec_word(input [31:0] ea, input [31:0] d);
      begin
         n = 0;
         while (vec_req !== 1'b1 && n < 50)
         begin
            @(negedge clock);
            n = n + 1;
         end
         check1(vec_req, 1'b1);
         check32(vec_addr, ea);
         vec_data = d;
         vec_ack = 1'b1;
         n = 0;
         while (vec_req !== 1'b0 && n < 50)
         begin
            @(negedge clock);
            n = n + 1;
         end
         check1(vec_req, 1'b0);
         vec_ack = 1'b0;
         vec_data = ~d;
      end
   endtask

   task pulse(input [6:0] m);
      begin
         @(negedge clock);
         pl = m;
         @(negedge clock);
         pl = 7'h00;
      end
   endtask

   task sr(input wr, input fo, input [4:0] sel, input [31:0] d);
      begin
         @(negedge clock);
         sr_write = wr;
         sr_read = !wr;
         sr_flags_only = fo;
         sr_sel = sel;
         sr_wdata = d;
         @(negedge clock);
         rd = sr_rdata;
         den = sr_denied;
         sr_write = 1'b0;
         sr_read = 1'b0;
      end
   endtask

   task gpr(input wr, input [3:0] a, input [31:0] d);
      begin
         @(negedge clock);
         gpr_we = wr;
         gpr_waddr = a;
         gpr_wdata = d;
         gpr_raddr = a;
         @(negedge clock);
         gpr_we = 1'b0;
         @(posedge clock);
         #1;
         rd = gpr_rdata;
      end
   endtask

   initial
   begin
      repeat (5) @(negedge clock);
      check1(handler_mode, 1'b0);
      reset = 1'b0;
      vec_word(32'h0000_0000, 32'h2000_1000);
      vec_word(32'h0000_0004, 32'h0000_0101);
      n = 0;
      while (running !== 1'b1 && n < 20)
      begin
         @(negedge clock);
         n = n + 1;
      end
      check1(running, 1'b1);
      check32(sp_value, 32'h2000_1000);
      check32(status_word, 32'h0100_0000);
      gpr(1'b0, 4'he, 32'h0000_0000);
      check32(rd, 32'h0fff_ffff);
      gpr(1'b0, 4'hf, 32'h0000_0000);
      check32(rd, 32'h0000_0100);
      gpr(1'b1, 4'h0, 32'ha5a5_5a5a);
      check32(rd, 32'ha5a5_5a5a);
      gpr(1'b1, 4'hc, 32'h1234_5678);
      check32(rd, 32'h1234_5678);
      pulse(P_PUSH);
      idle;
      check32(sp_value, 32'h2000_0ffc);
      pulse(P_POP);
      idle;
      check32(sp_value, 32'h2000_1000);
      check32(push_addr, 32'h2000_0ffc);
      sr(1'b1, 1'b0, `CMSR_SEL_STATUS, 32'hffff_ffff);
      sr(1'b0, 1'b0, `CMSR_SEL_STATUS, 32'h0000_0000);
      check32(rd, 32'hf80f_0000);
      sr(1'b0, 1'b0, `CMSR_SEL_EXEC, 32'h0000_0000);
      check32(rd, 32'h0000_0000);
      sr(1'b1, 1'b1, `CMSR_SEL_FLAGS, 32'h0000_0000);
      sr(1'b0, 1'b0, `CMSR_SEL_FLAGS, 32'h0000_0000);
      check32(rd, 32'h000f_0000);
      exc_number = 9'h00b;
      pulse(P_ENTER);
      idle;
      check1(handler_mode, 1'b1);
      sr(1'b1, 1'b0, `CMSR_SEL_NUM_EXEC, 32'h0000_0000);
      sr(1'b0, 1'b0, `CMSR_SEL_NUMBER, 32'h0000_0000);
      check32(rd, 32'h0000_000b);
      pulse(P_RETURN);
      idle;
      check1(handler_mode, 1'b0);
      sr(1'b1, 1'b0, `CMSR_SEL_PSP, 32'h3000_0000);
      sr(1'b1, 1'b0, `CMSR_SEL_CONTROL, 32'h0000_0002);
      idle;
      check32(sp_value, 32'h3000_0000);
      check1(use_psp, 1'b1);
      pulse(P_ENTER);
      idle;
      check32(sp_value, 32'h2000_1000);
      pulse(P_RETURN);
      sr(1'b1, 1'b0, `CMSR_SEL_CONTROL, 32'h0000_0003);
      idle;
      check1(privileged, 1'b0);
      sr(1'b0, 1'b0, `CMSR_SEL_CONTROL, 32'h0000_0000);
      check1(den, 1'b1);
      sr(1'b1, 1'b0, `CMSR_SEL_CONTROL, 32'h0000_0000);
      check1(den, 1'b1);
      idle;
      check1(privileged, 1'b0);
      sr(1'b0, 1'b0, `CMSR_SEL_PSP, 32'h0000_0000);
      check32(rd, 32'h3000_0000);
      pulse(P_CPS);
      check1(op_denied, 1'b1);
      pulse(P_SYS);
      check1(op_denied, 1'b1);
      pulse(P_SVC);
      check1(svc_taken, 1'b1);
      pulse(P_ENTER);
      idle;
      check1(privileged, 1'b1);
      sr(1'b1, 1'b0, `CMSR_SEL_CONTROL, 32'h0000_0000);
      pulse(P_RETURN);
      idle;
      check1(privileged, 1'b1);
      pulse(P_CPS);
      check1(op_denied, 1'b0);
      sr(1'b1, 1'b0, `CMSR_SEL_IRQ_MASK, 32'h0000_0001);
      sr(1'b1, 1'b0, `CMSR_SEL_ALL_MASK, 32'h0000_0001);
      sr(1'b1, 1'b0, `CMSR_SEL_PRIO, 32'h0000_0040);
      idle;
      check1(irq_masked, 1'b1);
      check1(all_masked, 1'b1);
      check32({24'h00_0000, prio_level}, 32'h0000_0040);
      report_and_stop;
   end
endmodule

bind cmsr_core_regs cmsr_core_regs_monitor u_monitor (
   .clock(clock), .reset(reset), .exc_enter(exc_enter), .exc_return(exc_return),
   .sr_read(sr_read), .sr_sel(sr_sel), .cps_req(cps_req), .svc_req(svc_req),
   .sr_rdata(sr_rdata), .sr_denied(sr_denied), .op_denied(op_denied), .svc_taken(svc_taken),
   .running(running), .handler_mode(handler_mode), .privileged(privileged), .use_psp(use_psp),
   .sp_value(sp_value), .push_addr(push_addr), .status_word(status_word)
);
